/* core/hpage_pkg.sv */
// Package for the host port page-address block: register map, fields, timing.
// Assumes a 40 MHz core clock and a 32-bit Avalon-MM slave port.
package hpage_pkg;
    // Register byte addresses on the configuration bus
    localparam logic [31:0] ADDR_HOST_CFG = 32'h4000_0008;
    localparam logic [31:0] ADDR_PAGE_TOP = 32'h4000_000c;
    localparam logic [31:0] ADDR_PAGE_UMID = 32'h4000_0010;
    localparam logic [31:0] ADDR_FIFO_STAT = 32'h4000_0014;
    // Configuration field positions
    localparam int CFG_ENA_BIT = 0;
    localparam int CFG_PAGE_MODE_SELECT_BIT = 1;
    localparam int CFG_DEMUXED_BUS_SELECT_BIT = 2;
    localparam int CFG_FULL_BIT = 3;
    localparam int CFG_BYTEAD_BIT = 4;
    localparam logic [4:0] CFG_RESET = 5'h00;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
    // Read FIFO depth
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_AW = 2;
    // Internal fetch latency in ns, rounded up to core cycles
    localparam int FETCH_NS = 100;
    localparam int CLK_NS = 25;
    localparam int FETCH_CYC = (FETCH_NS + CLK_NS - 1) / CLK_NS;
    // Host access kinds
    typedef enum logic [1:0] {
        ACC_CTRL,
        ACC_ADDR,
        ACC_DATA_INC,
        ACC_DATA
    } acc_type;
endpackage

/* core/hpage_fetch.sv */
// Internal fetch engine: latches the fetch address, pulses o_done after a fixed latency.
// Assumes the memory side answers i_mem_rdata whenever o_done pulses.
module hpage_fetch (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [31:0] i_addr,
    output logic o_busy,
    output logic o_done,
    output logic [31:0] o_mem_addr
);
    logic [3:0] cnt_r, cnt_nxt; // Remaining cycles
    logic [31:0] addr_r, addr_nxt; // Latched fetch address
    logic done_r, done_nxt; // One-cycle completion pulse

    // Next-state of the latency counter
    always_comb begin
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        done_nxt = 1'b0;
        if (i_start && cnt_r == 4'h0) begin
            cnt_nxt = 4'(hpage_pkg::FETCH_CYC);
            addr_nxt = i_addr;
        end else if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
            done_nxt = (cnt_r == 4'h1);
        end
    end

    // Registers only
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= 4'h0;
            addr_r <= hpage_pkg::BUS_ZERO;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_busy = (cnt_r != 4'h0);
    assign o_done = done_r;
    assign o_mem_addr = addr_r;
endmodule // hpage_fetch

/* core/hpage_port.sv */
// Host port page-address and ready control, with configuration registers.
// Assumes one core clock; host strobes synchronous to it; memory word on i_mem_rdata.
// Summary of operation
// - Top page byte drives address bits 31:24
// - Upper-middle byte drives address bits 23:16
// - Paging in demuxed mode or page mode
// - Upper register bits reserved, read zero
// - Auto-increment reads prefetch into read FIFO
// - Ready low until fetched read data valid
// - Address write flushes FIFO, waits for pending fetch
// - Page mode: host gives only low half
// - Demuxed select uses sixteen address lines
module hpage_port (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic i_host_strobe,
    input wire logic i_host_rnw,
    input wire logic [1:0] i_host_kind,
    input wire logic [15:0] i_host_addr_lines,
    input wire logic [31:0] i_host_wdata,
    output logic [31:0] o_host_rdata,
    output logic o_host_ready_out,
    output logic [31:0] o_mem_addr,
    input wire logic [31:0] i_mem_rdata,
    output logic o_page_mode_select,
    output logic o_demuxed_bus_select
);
    logic [4:0] cfg_r, cfg_nxt; // Port configuration
    logic [7:0] page_addr_top_byte_r, top_nxt; // Page byte, bits 31:24
    logic [7:0] page_addr_upper_mid_byte_r, umid_nxt; // Page byte, bits 23:16
    logic [31:0] rdata_r, rdata_nxt; // Bus read data
    logic rvalid_r, rvalid_nxt; // Read answer stage
    logic [31:0] host_address_port_r, haddr_nxt; // Host address register
    logic [31:0] fifo_mem [hpage_pkg::FIFO_DEPTH]; // Prefetch storage
    logic [hpage_pkg::FIFO_AW:0] count_r, count_nxt;
    logic [hpage_pkg::FIFO_AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [31:0] hrdata_r, hrdata_nxt; // Host read data
    logic ready_r, ready_nxt; // Ready to host
    logic busy_r, busy_nxt; // Host cycle in progress
    logic demand_r, demand_nxt; // Fetch answers a waiting host read
    logic pf_r, pf_nxt; // Prefetch armed by an auto-increment read
    logic pf_start; // This fetch fills the FIFO rather than a waiting read
    logic addr_wr; // Host address write accepted this cycle
    logic take_now; // Auto-increment read meets an empty FIFO
    logic [31:0] low_addr; // Host address, advanced past words already prefetched
    logic fetch_start, fetch_busy, fetch_done;
    logic [31:0] fetch_addr, full_addr;
    logic paged, fifo_push, fifo_pop, acc_new;
    hpage_pkg::acc_type kind;

    hpage_fetch u_fetch (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_start(fetch_start),
        .i_addr(full_addr),
        .o_busy(fetch_busy),
        .o_done(fetch_done),
        .o_mem_addr(o_mem_addr)
    );

    // Bus slave: registers written at once, reads answered one cycle later
    always_comb begin
        cfg_nxt = cfg_r;
        top_nxt = page_addr_top_byte_r;
        umid_nxt = page_addr_upper_mid_byte_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        if (avs_write && avs_byteenable[0]) begin
            // Only the core port writes page bytes; host has no path here
            case (avs_address)
                hpage_pkg::ADDR_HOST_CFG: cfg_nxt = avs_writedata[4:0];
                hpage_pkg::ADDR_PAGE_TOP: top_nxt = avs_writedata[7:0];
                hpage_pkg::ADDR_PAGE_UMID: umid_nxt = avs_writedata[7:0];
                default: cfg_nxt = cfg_r; // Unmapped write ignored
            endcase
        end
        if (avs_read && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            // Reserved upper bits come back as zero
            case (avs_address)
                hpage_pkg::ADDR_HOST_CFG: rdata_nxt = {27'h0, cfg_r};
                hpage_pkg::ADDR_PAGE_TOP: rdata_nxt = {24'h0, page_addr_top_byte_r};
                hpage_pkg::ADDR_PAGE_UMID: rdata_nxt = {24'h0, page_addr_upper_mid_byte_r};
                hpage_pkg::ADDR_FIFO_STAT: rdata_nxt = {29'h0, count_r};
                default: rdata_nxt = hpage_pkg::BUS_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_r <= hpage_pkg::CFG_RESET;
            page_addr_top_byte_r <= hpage_pkg::PAGE_RESET;
            page_addr_upper_mid_byte_r <= hpage_pkg::PAGE_RESET;
            rdata_r <= hpage_pkg::BUS_ZERO;
            rvalid_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            page_addr_top_byte_r <= top_nxt;
            page_addr_upper_mid_byte_r <= umid_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = avs_read && !rvalid_r;
    assign o_page_mode_select = cfg_r[hpage_pkg::CFG_PAGE_MODE_SELECT_BIT];
    assign o_demuxed_bus_select = cfg_r[hpage_pkg::CFG_DEMUXED_BUS_SELECT_BIT];

    // Address formation
    assign paged = cfg_r[hpage_pkg::CFG_DEMUXED_BUS_SELECT_BIT] || cfg_r[hpage_pkg::CFG_PAGE_MODE_SELECT_BIT];
    // A prefetch reads the word after those already queued, so words stay in order
    assign low_addr = host_address_port_r + (pf_start ? {29'h0, count_r} : hpage_pkg::BUS_ZERO);
    always_comb begin
        // Paged: page bytes over host low half; else full host address
        if (paged) begin
            full_addr = {page_addr_top_byte_r, page_addr_upper_mid_byte_r,
                         low_addr[15:0]};
        end else begin
            full_addr = low_addr;
        end
    end
    assign fetch_addr = full_addr;

    // Host side: one access per strobe rising while idle
    assign kind = hpage_pkg::acc_type'(i_host_kind);
    assign acc_new = i_host_strobe && !busy_r && cfg_r[hpage_pkg::CFG_ENA_BIT];
    assign fifo_pop = acc_new && i_host_rnw && kind == hpage_pkg::ACC_DATA_INC
                      && count_r != '0;
    assign addr_wr = acc_new && !i_host_rnw && kind == hpage_pkg::ACC_ADDR;
    assign take_now = acc_new && i_host_rnw && kind == hpage_pkg::ACC_DATA_INC && count_r == '0;
    // Disarmed, address-write or directly taken words never enter the FIFO, so
    // a discarded prefetch cannot leave a stale word behind
    assign fifo_push = fetch_done && !demand_r && pf_r && !addr_wr && !take_now;

    always_comb begin
        haddr_nxt = host_address_port_r;
        hrdata_nxt = hrdata_r;
        ready_nxt = ready_r;
        busy_nxt = busy_r;
        demand_nxt = demand_r;
        pf_nxt = pf_r;
        pf_start = 1'b0;
        fetch_start = 1'b0;
        count_nxt = count_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (!i_host_strobe) begin
            busy_nxt = 1'b0;
            ready_nxt = 1'b1;
        end
        if (acc_new) begin
            busy_nxt = 1'b1;
            case (kind)
                hpage_pkg::ACC_ADDR: begin
                    if (!i_host_rnw) begin
                        haddr_nxt = paged ? {16'h0, i_host_addr_lines} : i_host_wdata;
                        // Pending prefetch is discarded before ready returns
                        ready_nxt = (count_r == '0) && !fetch_busy;
                        pf_nxt = 1'b0; // New address stops the old stream
                        count_nxt = '0;
                        rp_nxt = wp_r;
                    end else begin
                        hrdata_nxt = host_address_port_r;
                    end
                end
                hpage_pkg::ACC_DATA_INC: begin
                    if (i_host_rnw && count_r != '0) begin
                        hrdata_nxt = fifo_mem[rp_r];
                        rp_nxt = rp_r + 1'b1;
                    end else if (i_host_rnw && fetch_done && !demand_r && pf_r) begin
                        // Prefetched word lands this very cycle: answer with it
                        hrdata_nxt = i_mem_rdata;
                    end else if (i_host_rnw) begin
                        ready_nxt = 1'b0;
                        demand_nxt = 1'b1;
                        fetch_start = !fetch_busy;
                    end
                    haddr_nxt = host_address_port_r + 32'h1;
                    if (i_host_rnw) begin
                        pf_nxt = 1'b1;
                    end
                end
                hpage_pkg::ACC_DATA: begin
                    if (i_host_rnw) begin
                        ready_nxt = 1'b0;
                        demand_nxt = 1'b1;
                        fetch_start = !fetch_busy;
                    end
                end
                default: hrdata_nxt = {27'h0, cfg_r};
            endcase
        end else if (busy_r && !ready_r) begin
            // Waiting for data or for a prefetch to settle
            if (demand_r && fetch_done) begin
                hrdata_nxt = i_mem_rdata;
                demand_nxt = 1'b0;
                ready_nxt = 1'b1;
            end else if (!demand_r && !fetch_busy) begin
                ready_nxt = 1'b1;
            end else if (demand_r && !fetch_busy) begin
                fetch_start = 1'b1;
            end
        end else if (pf_r && !fetch_busy && !fetch_done && !busy_r
                     && count_r < 3'(hpage_pkg::FIFO_DEPTH)) begin
            // Wait out the done cycle so the count already holds the last word
            fetch_start = 1'b1;
            pf_start = 1'b1;
        end
        if (fifo_push) begin
            wp_nxt = wp_r + 1'b1;
        end
        count_nxt = (acc_new && kind == hpage_pkg::ACC_ADDR && !i_host_rnw) ? '0
                    : count_r + {2'h0, fifo_push} - {2'h0, fifo_pop};
    end

    always_ff @(posedge i_ref_clk) begin
        if (fifo_push) begin
            fifo_mem[wp_r] <= i_mem_rdata;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            host_address_port_r <= hpage_pkg::BUS_ZERO;
            hrdata_r <= hpage_pkg::BUS_ZERO;
            ready_r <= 1'b1;
            busy_r <= 1'b0;
            demand_r <= 1'b0;
            pf_r <= 1'b0;
            count_r <= '0;
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            host_address_port_r <= haddr_nxt;
            hrdata_r <= hrdata_nxt;
            ready_r <= ready_nxt;
            busy_r <= busy_nxt;
            demand_r <= demand_nxt;
            pf_r <= pf_nxt;
            count_r <= count_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    assign o_host_rdata = hrdata_r;
    assign o_host_ready_out = ready_r;
endmodule // hpage_port

/* sim/hpage_mem_model.sv */
// Memory model beside the host port: answers each fetch address with a fixed pattern.
// Assumes the block samples the word when its fetch completes.
module hpage_mem_model (
    input wire logic i_ref_clk,
    input wire logic [31:0] i_mem_addr,
    output logic [31:0] o_mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // One cycle behind the address, so a design that skips its fetch wait reads stale data
    always_ff @(posedge i_ref_clk) begin
        o_mem_rdata <= i_mem_addr ^ 32'h5a5a_c3c3;
    end
endmodule // hpage_mem_model

/* sim/hpage_port_props.sv */
// Checker for the host port page block: bus waits, config bits, paging, ready.
// Assumes it is bound to hpage_port and sees only its ports.
module hpage_port_props (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic i_host_strobe,
    input wire logic o_host_ready_out,
    input wire logic [31:0] o_mem_addr,
    input wire logic o_page_mode_select,
    input wire logic o_demuxed_bus_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] page_r; // Shadow of both page bytes
    logic [15:0] page_nxt; // Next shadow value
    logic top_sel; // Bus points at the top page byte
    logic mid_sel; // Bus points at the upper-middle page byte
    logic cfg_wr; // Accepted config write, lane 0 on
    assign top_sel = avs_address == hpage_pkg::ADDR_PAGE_TOP;
    assign mid_sel = avs_address == hpage_pkg::ADDR_PAGE_UMID;
    assign cfg_wr = avs_write && avs_byteenable[0] && avs_address == hpage_pkg::ADDR_HOST_CFG;
    // Shadow follows lane-0 writes only, as the design ignores the rest
    always_comb begin
        page_nxt = page_r;
        if (avs_write && avs_byteenable[0] && top_sel)
            page_nxt[15:8] = avs_writedata[7:0];
        if (avs_write && avs_byteenable[0] && mid_sel)
            page_nxt[7:0] = avs_writedata[7:0];
    end
    // Shadow register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst)
            page_r <= 16'h0000;
        else
            page_r <= page_nxt;
    end
    read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer timing wrong");
    write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    page_mode_select_cfg_a: assert property (cfg_wr |=> o_page_mode_select == $past(avs_writedata[1]))
        else $error("page mode bit not taken");
    demux_cfg_a: assert property (cfg_wr |=> o_demuxed_bus_select == $past(avs_writedata[2]))
        else $error("demux bit not taken");
    reserved_zero_a: assert property (avs_read && !avs_waitrequest && (top_sel || mid_sel)
        |-> avs_readdata[31:8] == 24'h000000) else $error("reserved bits not zero");
    page_back_a: assert property (avs_read && !avs_waitrequest && (top_sel || mid_sel)
        |-> avs_readdata[7:0] == (top_sel ? page_r[15:8] : page_r[7:0])) else $error("page byte lost");
    paged_addr_a: assert property ((o_page_mode_select || o_demuxed_bus_select)
        && $changed(o_mem_addr) |-> o_mem_addr[31:16] == page_r) else $error("upper address wrong");
    ready_bound_a: assert property ($fell(o_host_ready_out) |-> ##[1:60] o_host_ready_out)
        else $error("ready stuck low");
    ready_cause_a: assert property ($fell(o_host_ready_out) |-> $past(i_host_strobe))
        else $error("ready fell without access");
    cover property ($rose(avs_read));
    cover property ($fell(o_host_ready_out));
    cover property (o_demuxed_bus_select && $changed(o_mem_addr));
endmodule // hpage_port_props

bind hpage_port hpage_port_props hpage_port_props_inst (.i_ref_clk, .i_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .i_host_strobe, .o_host_ready_out, .o_mem_addr, .o_page_mode_select, .o_demuxed_bus_select);

/* sim/test_host_port_page_address.sv */
// Self-checking bench for hpage_port: register bus, paging in three modes, ready, prefetch.
// Assumes hpage_mem_model answers the fetch address with a fixed pattern.
module test_host_port_page_address;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic i_host_strobe = 1'b0, i_host_rnw = 1'b0, avs_waitrequest, o_host_ready_out;
    logic o_page_mode_select, o_demuxed_bus_select;
    logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, i_host_wdata = 32'h0;
    logic [31:0] i_mem_rdata, avs_readdata, o_host_rdata, o_mem_addr, rd, a, b;
    logic [3:0] avs_byteenable = 4'hf;
    logic [1:0] i_host_kind = 2'h0;
    logic [15:0] i_host_addr_lines = 16'h0;
    logic [31:0] seed = 32'h8b57fca8; // Fixed seed keeps runs repeatable
    int err_total = 0, checks_done = 0, lows = 0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    hpage_port hpage_port_inst (.i_ref_clk, .i_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .i_host_strobe,
        .i_host_rnw, .i_host_kind, .i_host_addr_lines, .i_host_wdata, .o_host_rdata,
        .o_host_ready_out, .o_mem_addr, .i_mem_rdata, .o_page_mode_select, .o_demuxed_bus_select);
    hpage_mem_model hpage_mem_model_inst (.i_ref_clk, .i_mem_addr(o_mem_addr),
        .o_mem_rdata(i_mem_rdata));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Compare and count; reports at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One bus cycle; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] wd,
        input logic [3:0] be);
        @(posedge i_ref_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= ad;
        avs_writedata <= wd;
        avs_byteenable <= be;
        do @(posedge i_ref_clk); while (avs_waitrequest);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // One host access; counts cycles of ready low, strobe dropped after ready returns
    task automatic host(input logic [1:0] kind, input logic rnw, input logic [15:0] ln,
        input logic [31:0] wd);
        @(posedge i_ref_clk);
        i_host_strobe <= 1'b1;
        i_host_kind <= kind;
        i_host_rnw <= rnw;
        i_host_addr_lines <= ln;
        i_host_wdata <= wd;
        // Ready answers at the edge that takes the strobe; even one low cycle counts
        @(posedge i_ref_clk);
        #1;
        lows = 0;
        while (!o_host_ready_out) begin
            @(posedge i_ref_clk);
            #1;
            lows++;
        end
        @(posedge i_ref_clk);
        i_host_strobe <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        bus(1'b0, hpage_pkg::ADDR_PAGE_UMID, 32'h0, 4'hf);
        check(rd, {24'h0, hpage_pkg::PAGE_RESET});
        bus(1'b0, 32'h4000_0020, 32'h0, 4'hf);
        check(rd, hpage_pkg::BUS_ZERO);
        $display("reset test done");
        // Modes: demuxed, muxed paged, muxed full address
        for (int m = 0; m < 3; m++) begin
            a = rnd();
            b = rnd();
            bus(1'b1, hpage_pkg::ADDR_PAGE_TOP, {24'h0, a[31:24]}, 4'hf);
            bus(1'b1, hpage_pkg::ADDR_PAGE_UMID, {24'h0, a[23:16]}, 4'hf);
            bus(1'b1, hpage_pkg::ADDR_PAGE_TOP, b, 4'he);
            bus(1'b0, hpage_pkg::ADDR_PAGE_TOP, 32'h0, 4'hf);
            check(rd, {24'h0, a[31:24]});
            bus(1'b1, hpage_pkg::ADDR_HOST_CFG, m == 0 ? 32'h5 : m == 1 ? 32'h3 : 32'h1, 4'hf);
            @(negedge i_ref_clk); // Config bits settle after the taking edge
            check({o_demuxed_bus_select, o_page_mode_select}, m == 0 ? 2'h2 : {1'b0, m == 1});
            host(2'h1, 1'b0, a[15:0], b);
            host(2'h3, 1'b1, 16'h0, 32'h0);
            check(o_mem_addr, m < 2 ? a : b);
            check(o_host_rdata, (m < 2 ? a : b) ^ 32'h5a5a_c3c3);
            check({31'h0, lows > 0}, 32'h1);
        end
        $display("paging test done");
        host(2'h1, 1'b0, 16'h0, 32'h100);
        host(2'h2, 1'b1, 16'h0, 32'h0);
        check(o_host_rdata, 32'h100 ^ 32'h5a5a_c3c3);
        check({31'h0, lows > 0}, 32'h1);
        repeat (40) @(posedge i_ref_clk);
        host(2'h2, 1'b1, 16'h0, 32'h0);
        check(lows, 32'h0);
        check(o_host_rdata, 32'h101 ^ 32'h5a5a_c3c3);
        host(2'h0, 1'b1, 16'h0, 32'h0);
        check(lows, 32'h0);
        check(o_host_rdata, 32'h1);
        host(2'h1, 1'b0, 16'h0, 32'h200);
        check({31'h0, lows > 0}, 32'h1);
        bus(1'b1, hpage_pkg::ADDR_HOST_CFG, 32'h0, 4'hf);
        host(2'h3, 1'b1, 16'h0, 32'h0);
        check(lows, 32'h0);
        $display("prefetch test done");
        print_verdict();
    end
    // Watchdog well past the expected run length
    initial begin
        #(25 * 20000);
        err_total++;
        print_verdict();
    end
endmodule // test_host_port_page_address
